// file: verilog/fps_pkg.sv
// Package: timing constants, modes and states of the flash pulse sequencer
package fps_pkg;
  localparam int CLK_KHZ = 10000;
  // Times in ns as printed, cycle counts derived (least rounds up)
  localparam int PGM_PULSE_NS = 100000;
  localparam int ERS_PULSE_NS = 7000000;
  localparam int FLW_PULSE_NS = 14000000;
  localparam int STAB_NS = 10000;
  localparam int NS_PER_CYC = 1000000 / CLK_KHZ;
  localparam int PGM_PULSE_CYC = (PGM_PULSE_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int ERS_PULSE_CYC = (ERS_PULSE_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int FLW_PULSE_CYC = (FLW_PULSE_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int STAB_CYC = (STAB_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int PGM_MAX_PULSES = 150;
  localparam int ERS_MAX_PULSES = 1000;
  localparam int FLW_MAX_PULSES = 6000;
  localparam int CNT_W = 18;
  localparam int PCNT_W = 13;
  typedef enum logic [1:0] {
    FPS_OP_PGM = 2'h0,
    FPS_OP_ERS = 2'h1,
    FPS_OP_FLW = 2'h2
  } fps_op_t;
  typedef enum logic [6:0] {
    FPS_IDLE = 7'h01,
    FPS_SEL = 7'h02,
    FPS_PULSE = 7'h04,
    FPS_DESEL = 7'h08,
    FPS_VSEL = 7'h10,
    FPS_VCHK = 7'h20,
    FPS_DONE = 7'h40
  } fps_state_t;
endpackage

// file: verilog/fps_timer.sv
// Load-and-count-down timer giving a one-cycle expiry pulse
`timescale 1ns/1ns
module fps_timer
  import fps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic expired
);
  logic [CNT_W-1:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (load) begin
      cnt_reg <= load_val;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 18'h00001;
      if (cnt_reg == 18'h00001) begin
        run_reg <= 1'b0;
      end
    end
  end

  assign expired = run_reg && (cnt_reg == 18'h00001);
endmodule

// file: verilog/fps_seq.sv
// Flash pulse sequencer: drives mode selects and pulses of a flash array
// How it works
// (R01) Program pulse held 100 us, inside 95..105 us.
// (R02) One to 150 program pulses per word.
// (R03) Erase pulse held 7 ms, inside 6.65..7.35 ms.
// (R04) One to 1000 erase pulses per array.
// (R05) Flash-write pulse held 14 ms, inside 13.3..14.7 ms.
// (R06) One to 6000 flash-write pulses per array.
// (R07) Wait 10 us after program select before pulsing.
// (R08) Wait 10 us after erase select before pulsing.
// (R09) Wait 10 us after flash-write select before pulsing.
// (R10) Wait 10 us after verify select before sampling.
// (R11) Wait 10 us after deselecting a mode before treating array stable.
// (R12) Select, wait, pulse, deselect, wait, verify; repeat while failing under limit.
// (R13) Limit reached without pass: stop and report failure.
`timescale 1ns/1ns
module fps_seq
  import fps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [1:0] op_sel,
  input wire logic verify_ok,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [PCNT_W-1:0] pulse_count,
  output logic mode_pgm,
  output logic mode_ers,
  output logic mode_flw,
  output logic mode_verify,
  output logic pulse_on,
  output logic verify_sample
);
  // ----------------------------------------
  // State and timer
  // ----------------------------------------
  fps_state_t state_reg;
  fps_state_t state_next;
  fps_op_t op_reg;
  fps_op_t op_next;
  logic [PCNT_W-1:0] pcnt_reg;
  logic [PCNT_W-1:0] plimit;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_exp;

  fps_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_exp)
  );

  // ----------------------------------------
  // Limits and durations per operation
  // ----------------------------------------
  always_comb begin
    unique case (op_reg)
      FPS_OP_ERS: begin
        plimit = PCNT_W'(ERS_MAX_PULSES); // R04
      end
      FPS_OP_FLW: begin
        plimit = PCNT_W'(FLW_MAX_PULSES); // R06
      end
      default: begin
        plimit = PCNT_W'(PGM_MAX_PULSES); // R02
      end
    endcase
  end

  // Timer loads on every state entry that needs a wait
  always_comb begin
    tmr_load = 1'b0;
    tmr_val = CNT_W'(STAB_CYC);
    if (state_reg == FPS_IDLE && start) begin
      tmr_load = 1'b1; // R07 R08 R09
    end else if (state_reg == FPS_SEL && tmr_exp) begin
      tmr_load = 1'b1;
      unique case (op_reg)
        FPS_OP_ERS: tmr_val = CNT_W'(ERS_PULSE_CYC); // R03
        FPS_OP_FLW: tmr_val = CNT_W'(FLW_PULSE_CYC); // R05
        default: tmr_val = CNT_W'(PGM_PULSE_CYC); // R01
      endcase
    end else if (state_reg == FPS_PULSE && tmr_exp) begin
      tmr_load = 1'b1; // R11
    end else if (state_reg == FPS_DESEL && tmr_exp) begin
      tmr_load = 1'b1; // R10
    end else if (state_reg == FPS_VCHK && !verify_ok && pcnt_reg < plimit) begin
      tmr_load = 1'b1; // R12
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FPS_IDLE: begin
        if (start) begin
          state_next = FPS_SEL;
        end
      end
      FPS_SEL: begin
        if (tmr_exp) begin
          state_next = FPS_PULSE;
        end
      end
      FPS_PULSE: begin
        if (tmr_exp) begin
          state_next = FPS_DESEL;
        end
      end
      FPS_DESEL: begin
        if (tmr_exp) begin
          state_next = FPS_VSEL;
        end
      end
      FPS_VSEL: begin
        if (tmr_exp) begin
          state_next = FPS_VCHK;
        end
      end
      FPS_VCHK: begin
        if (verify_ok || pcnt_reg >= plimit) begin
          state_next = FPS_DONE; // R13
        end else begin
          state_next = FPS_SEL; // R12
        end
      end
      FPS_DONE: begin
        state_next = FPS_IDLE;
      end
      default: begin
        state_next = FPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= FPS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Decoded on the start edge so no stale mode line flashes up
  always_comb begin
    op_next = op_reg;
    if (state_reg == FPS_IDLE && start) begin
      if (op_sel == 2'h3) begin
        // Illegal code 3 falls back to program, the safest short pulse
        op_next = FPS_OP_PGM;
      end else begin
        op_next = fps_op_t'(op_sel);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      op_reg <= FPS_OP_PGM;
    end else begin
      op_reg <= op_next;
    end
  end

  // Pulse counter, cleared on start, bumped at each pulse end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pcnt_reg <= '0;
    end else if (state_reg == FPS_IDLE && start) begin
      pcnt_reg <= '0;
    end else if (state_reg == FPS_PULSE && tmr_exp) begin
      pcnt_reg <= pcnt_reg + 13'h0001; // R02 R04 R06
    end
  end

  // ----------------------------------------
  // Result
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      done <= 1'b0;
      fail <= 1'b0;
      pulse_count <= '0;
    end else begin
      done <= (state_next == FPS_DONE);
      if (state_reg == FPS_IDLE && start) begin
        fail <= 1'b0;
      end else if (state_reg == FPS_VCHK && state_next == FPS_DONE) begin
        fail <= !verify_ok; // R13
      end
      pulse_count <= pcnt_reg;
    end
  end

  // ----------------------------------------
  // Array drive, registered to keep pulse edges clean
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_pgm <= 1'b0;
      mode_ers <= 1'b0;
      mode_flw <= 1'b0;
      mode_verify <= 1'b0;
      pulse_on <= 1'b0;
      verify_sample <= 1'b0;
    end else begin
      mode_pgm <= op_next == FPS_OP_PGM && (state_next == FPS_SEL || state_next == FPS_PULSE);
      mode_ers <= op_next == FPS_OP_ERS && (state_next == FPS_SEL || state_next == FPS_PULSE);
      mode_flw <= op_next == FPS_OP_FLW && (state_next == FPS_SEL || state_next == FPS_PULSE);
      mode_verify <= (state_next == FPS_VSEL || state_next == FPS_VCHK);
      pulse_on <= (state_next == FPS_PULSE); // R01 R03 R05
      verify_sample <= (state_next == FPS_VCHK); // R10
    end
  end

  assign busy = (state_reg != FPS_IDLE);
endmodule

// file: test/fps_seq_sva.sv
// Port timing checker for the flash pulse sequencer
`timescale 1ns/1ns
module fps_seq_sva
  import fps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic verify_ok,
  input wire logic done,
  input wire logic fail,
  input wire logic [PCNT_W-1:0] pulse_count,
  input wire logic mode_pgm,
  input wire logic mode_ers,
  input wire logic mode_flw,
  input wire logic mode_verify,
  input wire logic pulse_on,
  input wire logic verify_sample
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [CNT_W-1:0] pw_reg, sc_reg, vc_reg, dc_reg;
  wire logic sel = mode_pgm | mode_ers | mode_flw;
  // Counters rather than repetition: waits run to 140000 cycles
  always_ff @(posedge sys_clk) begin
    pw_reg <= (reset_n && pulse_on) ? pw_reg + 1'b1 : '0;
    sc_reg <= (reset_n && sel && !pulse_on) ? sc_reg + 1'b1 : '0;
    vc_reg <= (reset_n && mode_verify) ? vc_reg + 1'b1 : '0;
    dc_reg <= (reset_n && !sel && !mode_verify) ? dc_reg + 1'b1 : '0;
  end
  property p_width;
    $fell(pulse_on) |-> pw_reg == ($past(mode_pgm) ? PGM_PULSE_CYC :
      $past(mode_ers) ? ERS_PULSE_CYC : FLW_PULSE_CYC);
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_stab;
    $rose(pulse_on) |-> $past(sel) && sc_reg >= STAB_CYC;
  endproperty
  a_stab: assert property (p_stab) else $error("select wait");
  property p_vstab;
    $rose(verify_sample) |-> mode_verify && vc_reg >= STAB_CYC;
  endproperty
  a_vstab: assert property (p_vstab) else $error("verify wait");
  property p_desel;
    $rose(mode_verify) |-> dc_reg >= STAB_CYC;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect wait");
  property p_pass;
    verify_sample && verify_ok |=> done && !fail && !mode_verify;
  endproperty
  a_pass: assert property (p_pass) else $error("pass end");
  property p_retry;
    verify_sample && !verify_ok && pulse_count < PGM_MAX_PULSES |=> !done ##[0:1] sel;
  endproperty
  a_retry: assert property (p_retry) else $error("retry");
  property p_limit;
    $rose(pulse_on) |-> pulse_count < (mode_pgm ? PGM_MAX_PULSES :
      mode_ers ? ERS_MAX_PULSES : FLW_MAX_PULSES);
  endproperty
  a_limit: assert property (p_limit) else $error("pulse limit");
  property p_fail;
    done && fail |-> pulse_count == PGM_MAX_PULSES || pulse_count == ERS_MAX_PULSES ||
      pulse_count == FLW_MAX_PULSES;
  endproperty
  a_fail: assert property (p_fail) else $error("fail report");
  c_ers: cover property ($rose(pulse_on) && mode_ers);
  c_ok: cover property (done && !fail);
  c_bad: cover property (verify_sample && !verify_ok);
  c_flw: cover property ($rose(pulse_on) && mode_flw);
endmodule

// file: test/fps_flash_model.sv
// Behavioural flash array answering verify reads
`timescale 1ns/1ns
module fps_flash_model
  import fps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic busy,
  input wire logic mode_verify,
  input wire logic pulse_on,
  input wire logic [PCNT_W-1:0] need,
  output logic verify_ok
);
  logic [PCNT_W-1:0] hits_reg;
  logic on_reg;
  logic junk_reg = 1'b0;
  always_ff @(posedge sys_clk) begin
    on_reg <= pulse_on;
    junk_reg <= !junk_reg;
    if (!busy) hits_reg <= '0;
    else if (pulse_on && !on_reg) hits_reg <= hits_reg + 1'b1;
  end
  // Unread line toggles so a stale level never passes
  assign verify_ok = mode_verify ? (hits_reg >= need) : junk_reg;
endmodule

// file: test/fps_seq_tb_top.sv
// Testbench for the flash pulse sequencer
`timescale 1ns/1ns
module fps_seq_tb_top
  import fps_pkg::*;
;
  logic sys_clk = 1'b0, reset_n = 1'b0, start = 1'b0, verify_ok, busy, done, fail;
  logic [1:0] op_sel = 2'h0;
  logic [PCNT_W-1:0] need = 13'h0001, pulse_count;
  logic mode_pgm, mode_ers, mode_flw, mode_verify, pulse_on, verify_sample;
  int num_errors = 0, num_checks = 0, cyc = 0, op_cyc = 0;
  always #50 sys_clk = ~sys_clk;
  fps_seq i_fps_seq (.sys_clk, .reset_n, .start, .op_sel, .verify_ok, .busy, .done, .fail,
    .pulse_count, .mode_pgm, .mode_ers, .mode_flw, .mode_verify, .pulse_on, .verify_sample);
  fps_flash_model i_fps_flash_model (.sys_clk, .busy, .mode_verify, .pulse_on, .need,
    .verify_ok);
  // --------
  // Tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Start taken on the second edge; the right mode line must follow at once
  task automatic start_op(input logic [1:0] op, input logic [PCNT_W-1:0] n);
    logic [2:0] exp_mode;
    exp_mode = (op == 2'h1) ? 3'h2 : (op == 2'h2) ? 3'h1 : 3'h4;
    @(posedge sys_clk);
    op_sel <= op;
    need <= n;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(negedge sys_clk);
    chk(busy, 1'b1);
    chk({mode_pgm, mode_ers, mode_flw}, exp_mode);
  endtask
  task automatic run_op(input logic [1:0] op, input logic [PCNT_W-1:0] n);
    start_op(op, n);
    op_cyc = 0;
    do begin
      @(negedge sys_clk);
      op_cyc++;
    end while (done !== 1'b1);
  endtask
  task automatic t_first();
    run_op(2'h0, 13'h0001);
    chk(pulse_count, 16'h0001);
    chk(fail, 1'b0);
    chk(op_cyc, 3 * STAB_CYC + PGM_PULSE_CYC + 1);
    @(negedge sys_clk);
    chk({done, busy}, 2'h0);
  endtask
  // Flash-write select wait, then a reset in mid-pulse drops busy, done, fail, mode_pgm, mode_flw, pulse_on and verify_sample
  task automatic t_flw_reset();
    start_op(2'h2, 13'h0001);
    repeat (STAB_CYC - 1) @(negedge sys_clk);
    chk(pulse_on, 1'b0);
    @(negedge sys_clk);
    chk({pulse_on, mode_flw}, 2'h3);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk({busy, done, fail, mode_pgm, mode_flw, pulse_on, verify_sample}, 7'h00);
  endtask
  // Erase request mid-program must be ignored
  task automatic t_retry();
    fork
      run_op(2'h0, 13'h0003);
      begin
        repeat (50) @(posedge sys_clk);
        op_sel <= 2'h1;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        @(negedge sys_clk);
        chk({mode_pgm, mode_ers}, 2'h2);
      end
    join
    chk(pulse_count, 16'h0003);
    chk(fail, 1'b0);
    chk(op_cyc, 3 * (3 * STAB_CYC + PGM_PULSE_CYC + 1));
  endtask
  // Code 3 must run as a program operation
  task automatic t_illegal();
    run_op(2'h3, 13'h0002);
    chk(pulse_count, 16'h0002);
    chk(fail, 1'b0);
  endtask
  task automatic t_erase();
    run_op(2'h1, 13'h0001);
    chk(pulse_count, 16'h0001);
    chk(fail, 1'b0);
    chk(op_cyc, 3 * STAB_CYC + ERS_PULSE_CYC + 1);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_first();
    t_flw_reset();
    t_retry();
    t_illegal();
    t_erase();
    end_of_test();
  end
endmodule
bind fps_seq fps_seq_sva i_fps_seq_sva (.sys_clk, .reset_n, .verify_ok, .done, .fail,
  .pulse_count, .mode_pgm, .mode_ers, .mode_flw, .mode_verify, .pulse_on, .verify_sample);
